// file: src/irq_ctrl.sv
// Prioritised vectored interrupt controller with capture edge status and AHB-Lite register slave
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
module irq_ctrl
   import irq_ctrl_pkg::*;
#(
   parameter int SLOW_DIVIDE = SLOW_DIV
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Hardware sources (same clock domain) indexed by level-1
   input wire logic [NUM_SRC-1:0] source_event,
   // Pins from outside the clock domain
   input wire logic capture_input_0,
   input wire logic capture_input_1,
   input wire logic [3:0] port_pins,
   input wire logic bus_dp,
   input wire logic bus_dm,
   input wire logic serial_data_pad,
   input wire logic serial_pad_input_mode,
   // Core handshake
   input wire logic global_irq_enable,
   input wire logic instr_boundary,
   input wire logic return_from_irq,
   output core_req_t core_req
);
   logic [7:0] capture_edge_status_reg;
   logic [NUM_SRC-1:0] posted_reg;
   logic [7:0] source_mask0_reg, source_mask1_reg, source_mask2_reg;
   logic soft_irq_enable_reg;
   logic [NUM_SRC-1:0] mask_vec, pending;
   logic [2:0] cap0_sync, cap1_sync, dp_sync, dm_sync, sd_sync;
   logic [11:0] port_sync;
   logic [NUM_SRC-1:0] hw_event;
   logic [15:0] slow_cnt_reg;
   logic slow_tick;
   logic [2:0] low_cnt_reg;
   logic data_low_evt;
   logic dp_lvl, dm_lvl, sd_lvl;
   logic [1:0] cap0_hist_reg, cap1_hist_reg;
   logic [3:0] port_hist_reg;
   disp_state_t state_reg;
   logic [3:0] disp_cnt_reg;
   logic [4:0] sel_src;
   logic sel_valid;
   logic take;
   logic [NUM_SRC-1:0] take_clr;
   // Bus phase capture
   logic wr_pend_reg;
   logic [7:0] addr_reg;
   logic acc;
   logic [7:0] wbyte;
   logic [NUM_SRC-1:0] clr_wr, set_wr;

   // Pin synchronisers: change counts once stages 2 and 3 agree
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cap0_sync <= 3'h0;
         cap1_sync <= 3'h0;
         // Start at the idle bus levels so no false activity follows reset
         dp_sync <= 3'h7;
         dm_sync <= 3'h0;
         sd_sync <= 3'h7;
         port_sync <= 12'h000;
      end else begin
         cap0_sync <= {cap0_sync[1:0], capture_input_0};
         cap1_sync <= {cap1_sync[1:0], capture_input_1};
         dp_sync <= {dp_sync[1:0], bus_dp};
         dm_sync <= {dm_sync[1:0], bus_dm};
         sd_sync <= {sd_sync[1:0], serial_data_pad};
         port_sync <= {port_sync[7:0], port_pins};
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cap0_hist_reg <= 2'h0;
         cap1_hist_reg <= 2'h0;
         port_hist_reg <= 4'h0;
      end else begin
         if (cap0_sync[1] == cap0_sync[2]) cap0_hist_reg <= {cap0_hist_reg[0], cap0_sync[2]};
         if (cap1_sync[1] == cap1_sync[2]) cap1_hist_reg <= {cap1_hist_reg[0], cap1_sync[2]};
         for (int i = 0; i < 4; i++) begin
            if (port_sync[4+i] == port_sync[8+i]) port_hist_reg[i] <= port_sync[8+i];
         end
      end
   end

   logic cap0_rise, cap0_fall, cap1_rise, cap1_fall;
   logic [3:0] port_edge;
   assign cap0_rise = (cap0_sync[1] == cap0_sync[2]) && cap0_sync[2] && !cap0_hist_reg[0];
   assign cap0_fall = (cap0_sync[1] == cap0_sync[2]) && !cap0_sync[2] && cap0_hist_reg[0];
   assign cap1_rise = (cap1_sync[1] == cap1_sync[2]) && cap1_sync[2] && !cap1_hist_reg[0];
   assign cap1_fall = (cap1_sync[1] == cap1_sync[2]) && !cap1_sync[2] && cap1_hist_reg[0];
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         port_edge[i] = (port_sync[4+i] == port_sync[8+i]) && (port_sync[8+i] != port_hist_reg[i]);
      end
   end
   // Unsettled stages read as the idle bus state, never as activity
   assign dp_lvl = (dp_sync[1] == dp_sync[2]) ? dp_sync[2] : 1'b1;
   assign dm_lvl = (dm_sync[1] == dm_sync[2]) ? dm_sync[2] : 1'b0;
   assign sd_lvl = (sd_sync[1] == sd_sync[2]) ? sd_sync[2] : 1'b1;

   // Slow tick divider standing in for the 32 kHz sampling clock
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         slow_cnt_reg <= 16'h0000;
      end else if (slow_cnt_reg == 16'(SLOW_DIVIDE - 1)) begin
         slow_cnt_reg <= 16'h0000;
      end else begin
         slow_cnt_reg <= slow_cnt_reg + 16'h0001;
      end
   end
   assign slow_tick = (slow_cnt_reg == 16'(SLOW_DIVIDE - 1));

   // Data low detector, fires once per low period
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt_reg <= 3'h0;
      end else if (!serial_pad_input_mode || sd_lvl) begin
         low_cnt_reg <= 3'h0;
      end else if (slow_tick && low_cnt_reg != 3'(DATA_LOW_TICKS)) begin
         low_cnt_reg <= low_cnt_reg + 3'h1;
      end
   end
   assign data_low_evt = slow_tick && serial_pad_input_mode && !sd_lvl
                         && (low_cnt_reg == 3'(DATA_LOW_TICKS - 1));

   // Source index i is level i+1
   always_comb begin
      hw_event = source_event;
      hw_event[PRIO_BUS_ACTIVE-1] = source_event[PRIO_BUS_ACTIVE-1]
                                  | (!dp_lvl && dm_lvl) | (!dp_lvl && !dm_lvl);
      hw_event[PRIO_CAPTURE0-1] = source_event[PRIO_CAPTURE0-1] | cap0_rise | cap0_fall;
      hw_event[PRIO_CAPTURE1-1] = source_event[PRIO_CAPTURE1-1] | cap1_rise | cap1_fall;
      hw_event[PRIO_DATA_LOW-1] = source_event[PRIO_DATA_LOW-1] | data_low_evt;
      hw_event[PRIO_PORT0-1] = port_edge[0];
      hw_event[PRIO_PORT1-1] = port_edge[1];
      hw_event[PRIO_PORT2-1] = port_edge[2];
      hw_event[PRIO_PORT3-1] = port_edge[3];
      hw_event[21] = 1'b0;
      hw_event[22] = 1'b0;
      hw_event[23] = 1'b0;
   end

   // AHB-Lite: zero wait states, writes applied in data phase
   assign acc = hsel && hready && htrans[1];
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= acc && hwrite;
         // Register index; each register sits in its own word, so byte address is four times the index
         if (acc) addr_reg <= haddr[9:2];
      end
   end
   assign wbyte = hwdata[7:0];
   always_comb begin
      clr_wr = '0;
      set_wr = '0;
      if (wr_pend_reg) begin
         for (int b = 0; b < 8; b++) begin
            if (addr_reg == POSTED_CLEAR0_OFS) begin
               clr_wr[b] = !soft_irq_enable_reg && !wbyte[b];
               set_wr[b] = soft_irq_enable_reg && wbyte[b];
            end
            if (addr_reg == POSTED_CLEAR1_OFS) begin
               clr_wr[8+b] = !soft_irq_enable_reg && !wbyte[b];
               set_wr[8+b] = soft_irq_enable_reg && wbyte[b];
            end
            if (addr_reg == POSTED_CLEAR2_OFS && b < 8 && 16 + b < NUM_SRC) begin
               clr_wr[16+b] = !soft_irq_enable_reg && !wbyte[b];
               set_wr[16+b] = soft_irq_enable_reg && wbyte[b];
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         source_mask0_reg <= REG_RESET;
         source_mask1_reg <= REG_RESET;
         source_mask2_reg <= REG_RESET;
         soft_irq_enable_reg <= 1'b0;
      end else if (wr_pend_reg) begin
         if (addr_reg == SOURCE_MASK0_OFS) source_mask0_reg <= wbyte;
         if (addr_reg == SOURCE_MASK1_OFS) source_mask1_reg <= wbyte;
         if (addr_reg == SOURCE_MASK2_OFS) source_mask2_reg <= wbyte;
         if (addr_reg == SOURCE_MASK3_OFS) soft_irq_enable_reg <= wbyte[SOFT_IRQ_BIT];
      end
   end

   // Capture edge status: set wins over write-one clear
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         capture_edge_status_reg <= REG_RESET;
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (wr_pend_reg && addr_reg == CAPTURE_EDGE_STATUS_OFS && wbyte[b]) begin
               capture_edge_status_reg[b] <= 1'b0;
            end
         end
         if (cap0_rise) capture_edge_status_reg[0] <= 1'b1;
         if (cap0_fall) capture_edge_status_reg[1] <= 1'b1;
         if (cap1_rise) capture_edge_status_reg[2] <= 1'b1;
         if (cap1_fall) capture_edge_status_reg[3] <= 1'b1;
         capture_edge_status_reg[7:4] <= 4'h0;
      end
   end

   // Posted flags: hardware or software set wins over any clear
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         posted_reg <= '0;
      end else begin
         posted_reg <= ((posted_reg & ~clr_wr & ~take_clr) | hw_event | set_wr);
      end
   end

   // Mask independent of posting
   // Sleep level has no mask bit in this byte map and stays masked
   assign mask_vec = {1'b0, source_mask2_reg, source_mask1_reg, source_mask0_reg};
   assign pending = posted_reg & mask_vec;

   // Lowest number wins
   always_comb begin
      sel_src = 5'h00;
      sel_valid = 1'b0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pending[i]) begin
            sel_src = 5'(i + 1);
            sel_valid = 1'b1;
         end
      end
   end

   assign take = (state_reg != ST_DISPATCH) && sel_valid && global_irq_enable && instr_boundary;
   always_comb begin
      take_clr = '0;
      if (take) take_clr[sel_src-1] = 1'b1;
   end

   // Dispatch sequencer
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         disp_cnt_reg <= 4'h0;
         core_req <= '0;
      end else begin
         core_req.dispatch_req <= 1'b0;
         core_req.push_pc_high <= 1'b0;
         core_req.push_pc_low <= 1'b0;
         core_req.push_flags <= 1'b0;
         core_req.clear_flags <= 1'b0;
         case (state_reg)
            ST_IDLE, ST_SERVICE: begin
               if (return_from_irq) state_reg <= ST_IDLE;
               if (take) begin
                  state_reg <= ST_DISPATCH;
                  disp_cnt_reg <= 4'h0;
                  core_req.dispatch_req <= 1'b1;
                  core_req.dispatch_busy <= 1'b1;
                  core_req.vector <= {1'b0, sel_src, 2'b00};
               end
            end
            ST_DISPATCH: begin
               disp_cnt_reg <= disp_cnt_reg + 4'h1;
               core_req.push_pc_high <= (disp_cnt_reg == 4'h0);
               core_req.push_pc_low <= (disp_cnt_reg == 4'h1);
               core_req.push_flags <= (disp_cnt_reg == 4'h2);
               core_req.clear_flags <= (disp_cnt_reg == 4'h3);
               if (disp_cnt_reg == 4'(DISPATCH_CYCLES - 1)) begin
                  state_reg <= ST_SERVICE;
                  core_req.dispatch_busy <= 1'b0;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Read data in the data phase
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (acc && !hwrite) begin
         case (haddr[9:2])
            CAPTURE_EDGE_STATUS_OFS: hrdata <= {24'h0, capture_edge_status_reg};
            POSTED_CLEAR0_OFS: hrdata <= {24'h0, posted_reg[7:0]};
            POSTED_CLEAR1_OFS: hrdata <= {24'h0, posted_reg[15:8]};
            POSTED_CLEAR2_OFS: hrdata <= {24'h0, posted_reg[23:16]};
            SOURCE_MASK0_OFS: hrdata <= {24'h0, source_mask0_reg};
            SOURCE_MASK1_OFS: hrdata <= {24'h0, source_mask1_reg};
            SOURCE_MASK2_OFS: hrdata <= {24'h0, source_mask2_reg};
            SOURCE_MASK3_OFS: hrdata <= {24'h0, soft_irq_enable_reg, 7'h00};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   a_status_w1c: assert property (@(posedge core_clk) disable iff (!reset_n)
      (wr_pend_reg && addr_reg == CAPTURE_EDGE_STATUS_OFS && wbyte[0] && !cap0_rise)
      |=> !capture_edge_status_reg[0]) else $error("capture bit 0 not cleared");
   a_status_rise: assert property (@(posedge core_clk) disable iff (!reset_n)
      cap0_rise |=> capture_edge_status_reg[0]) else $error("capture rise not flagged");
   a_mask_gates: assert property (@(posedge core_clk) disable iff (!reset_n)
      take |-> mask_vec[sel_src-1]) else $error("masked source taken");
   a_enable_gates: assert property (@(posedge core_clk) disable iff (!reset_n)
      core_req.dispatch_req |-> $past(global_irq_enable)) else $error("dispatch without enable");
   a_vector_value: assert property (@(posedge core_clk) disable iff (!reset_n)
      core_req.dispatch_req |-> core_req.vector[1:0] == 2'b00 && core_req.vector != 8'h00)
      else $error("bad vector");
   a_dispatch_len: assert property (@(posedge core_clk) disable iff (!reset_n)
      core_req.dispatch_req |-> ##12 core_req.dispatch_busy ##1 !core_req.dispatch_busy)
      else $error("dispatch length wrong");
   // Length of the current busy run, so a gap inside dispatch is caught too
   logic [4:0] busy_run_reg;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_run_reg <= 5'h00;
      end else if (core_req.dispatch_busy) begin
         busy_run_reg <= busy_run_reg + 5'h01;
      end else begin
         busy_run_reg <= 5'h00;
      end
   end
   a_busy_run: assert property (@(posedge core_clk) disable iff (!reset_n)
      $fell(core_req.dispatch_busy) |-> busy_run_reg == 5'(DISPATCH_CYCLES)) else $error("busy run wrong");
   a_push_order: assert property (@(posedge core_clk) disable iff (!reset_n)
      core_req.dispatch_req |-> ##1 core_req.push_pc_high ##1 core_req.push_pc_low ##1 core_req.push_flags
      ##1 core_req.clear_flags) else $error("push order wrong");
   a_taken_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
      (take && !hw_event[sel_src-1] && !set_wr[sel_src-1]) |=> !posted_reg[$past(sel_src)-1])
      else $error("taken flag not cleared");
   a_mask_keeps: assert property (@(posedge core_clk) disable iff (!reset_n)
      (posted_reg[0] && !take_clr[0] && !clr_wr[0]) |=> posted_reg[0]) else $error("posted flag lost");
   c_dispatch: cover property (@(posedge core_clk) disable iff (!reset_n) core_req.dispatch_req);
   c_soft_post: cover property (@(posedge core_clk) disable iff (!reset_n) |set_wr);
   c_data_low: cover property (@(posedge core_clk) disable iff (!reset_n) data_low_evt);
endmodule : irq_ctrl

// file: src/irq_ctrl_pkg.sv
// Package: register map, source numbering, dispatch timing and carrier types for the interrupt controller
package irq_ctrl_pkg;
   localparam int NUM_LEVELS = 26;
   localparam int NUM_SRC = 25;
   localparam logic [7:0] CAPTURE_EDGE_STATUS_OFS = 8'h2C;
   localparam logic [7:0] POSTED_CLEAR0_OFS = 8'hDA;
   localparam logic [7:0] POSTED_CLEAR1_OFS = 8'hDB;
   localparam logic [7:0] POSTED_CLEAR2_OFS = 8'hDC;
   localparam logic [7:0] SOURCE_MASK3_OFS = 8'hDE;
   localparam logic [7:0] SOURCE_MASK2_OFS = 8'hDF;
   localparam logic [7:0] SOURCE_MASK1_OFS = 8'hE1;
   localparam logic [7:0] SOURCE_MASK0_OFS = 8'hE0;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int SOFT_IRQ_BIT = 7;
   localparam logic [3:0] CAP0_RISE_BIT = 4'h0;
   localparam int DISPATCH_CYCLES = 13;
   localparam int LONG_JUMP_CYCLES = 7;
   localparam int VECTOR_SHIFT = 2;
   localparam int CORE_CLK_HZ = 20000000;
   localparam int SLOW_CLK_HZ = 32768;
   localparam int SLOW_DIV = CORE_CLK_HZ / SLOW_CLK_HZ;
   localparam int DATA_LOW_TICKS = 6;
   localparam logic [4:0] PRIO_POWER = 5'h01;
   localparam logic [4:0] PRIO_CAPTURE0 = 5'h0F;
   localparam logic [4:0] PRIO_CAPTURE1 = 5'h10;
   localparam logic [4:0] PRIO_BUS_ACTIVE = 5'h0C;
   localparam logic [4:0] PRIO_DATA_LOW = 5'h13;
   localparam logic [4:0] PRIO_PORT0 = 5'h05;
   localparam logic [4:0] PRIO_PORT1 = 5'h06;
   localparam logic [4:0] PRIO_PORT2 = 5'h14;
   localparam logic [4:0] PRIO_PORT3 = 5'h15;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DISPATCH = 3'b010,
      ST_SERVICE = 3'b100
   } disp_state_t;

   // Handshake toward the core: vector, dispatch pulse, dispatch busy
   typedef struct packed {
      logic dispatch_req;
      logic dispatch_busy;
      logic push_pc_high;
      logic push_pc_low;
      logic push_flags;
      logic clear_flags;
      logic [7:0] vector;
   } core_req_t;
endpackage : irq_ctrl_pkg

// file: verif/core_model.sv
// Behavioural core: instruction boundaries, global enable flag, return from interrupt
`timescale 1ns/10ps
module core_model
   import irq_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Controller side
   input wire core_req_t core_req,
   output logic global_irq_enable,
   output logic instr_boundary,
   output logic return_from_irq,
   // Bench commands
   input wire logic irq_enable_set,
   input wire logic return_req
);
   logic [1:0] cyc_reg;
   // Three-cycle instructions, no boundary while the call is running
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cyc_reg <= 2'h0;
         instr_boundary <= 1'b0;
      end else begin
         cyc_reg <= (cyc_reg == 2'h2) ? 2'h0 : cyc_reg + 2'h1;
         instr_boundary <= (cyc_reg == 2'h2) && !core_req.dispatch_busy;
      end
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         global_irq_enable <= 1'b0;
         return_from_irq <= 1'b0;
      end else begin
         return_from_irq <= return_req;
         if (core_req.clear_flags) begin
            global_irq_enable <= 1'b0;
         end else if (irq_enable_set || return_req) begin
            global_irq_enable <= 1'b1;
         end
      end
   end
endmodule : core_model

// file: verif/tb_top.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
module tb_top
   import irq_ctrl_pkg::*;
;
   localparam int DIV = 4;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [NUM_SRC-1:0] source_event = '0;
   logic cap0 = 1'b0;
   logic cap1 = 1'b0;
   logic [3:0] port_pins = 4'h0;
   logic bus_dp = 1'b1;
   logic bus_dm = 1'b0;
   logic serial_data_pad = 1'b1;
   logic sin_mode = 1'b0;
   logic irq_enable_set = 1'b0;
   logic return_req = 1'b0;
   logic global_irq_enable;
   logic ib;
   logic rti;
   core_req_t core_req;
   int miscompares = 0;
   int n_tests = 0;

   initial begin
      forever #25 core_clk = ~core_clk;
   end

   irq_ctrl #(.SLOW_DIVIDE(DIV)) DUT (.core_clk(core_clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .source_event(source_event), .capture_input_0(cap0),
      .capture_input_1(cap1), .port_pins(port_pins), .bus_dp(bus_dp), .bus_dm(bus_dm),
      .serial_data_pad(serial_data_pad), .serial_pad_input_mode(sin_mode), .global_irq_enable(global_irq_enable),
      .instr_boundary(ib), .return_from_irq(rti), .core_req(core_req));

   core_model core (.core_clk(core_clk), .reset_n(reset_n), .core_req(core_req),
      .global_irq_enable(global_irq_enable), .instr_boundary(ib), .return_from_irq(rti),
      .irq_enable_set(irq_enable_set), .return_req(return_req));

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize

   task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check8

   task automatic check1(input string name, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask : check1

   // Wait for the slave, a bounded number of edges
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         miscompares++;
         summarize();
      end
   endtask : wait_ready

   task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [7:0] wd, output logic [7:0] rv);
      @(posedge core_clk);
      haddr <= {22'h0, ofs, 2'h0};
      hwrite <= wr;
      htrans <= 2'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_ready();
      rv = hrdata[7:0];
      check1("hresp", 1'b0, hresp);
   endtask : ahb

   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      logic [7:0] v;
      ahb(1'b1, ofs, d, v);
   endtask : wr

   task automatic rdchk(input logic [7:0] ofs, input logic [7:0] exp);
      logic [7:0] v;
      ahb(1'b0, ofs, 8'h00, v);
      check8($sformatf("reg %h", ofs), exp, v);
   endtask : rdchk

   task automatic cmd(input logic g, input logic r);
      @(posedge core_clk);
      irq_enable_set <= g;
      return_req <= r;
      @(posedge core_clk);
      irq_enable_set <= 1'b0;
      return_req <= 1'b0;
   endtask : cmd

   task automatic settle();
      repeat (6) @(posedge core_clk);
   endtask : settle

   task automatic clr_all();
      wr(POSTED_CLEAR0_OFS, 8'h00);
      wr(POSTED_CLEAR1_OFS, 8'h00);
      wr(POSTED_CLEAR2_OFS, 8'h00);
   endtask : clr_all

   task automatic expect_dispatch(input logic [7:0] vec);
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (core_req.dispatch_req !== 1'b1 && n < 400);
      if (core_req.dispatch_req !== 1'b1) begin
         miscompares++;
         summarize();
      end
      check8("vector", vec, core_req.vector);
      @(negedge core_clk);
      check1("push_pc_high", 1'b1, core_req.push_pc_high);
      @(negedge core_clk);
      check1("push_pc_low", 1'b1, core_req.push_pc_low);
      @(negedge core_clk);
      check1("push_flags", 1'b1, core_req.push_flags);
      @(negedge core_clk);
      check1("clear_flags", 1'b1, core_req.clear_flags);
      repeat (8) @(negedge core_clk);
      check1("busy last", 1'b1, core_req.dispatch_busy);
      @(negedge core_clk);
      check1("busy off", 1'b0, core_req.dispatch_busy);
   endtask : expect_dispatch

   task automatic expect_none(input int cycles);
      int hits;
      hits = 0;
      repeat (cycles) begin
         @(negedge core_clk);
         if (core_req.dispatch_req === 1'b1) hits++;
      end
      check8("dispatches", 8'h00, 8'(hits));
   endtask : expect_none

   task automatic t_capture();
      rdchk(CAPTURE_EDGE_STATUS_OFS, REG_RESET);
      rdchk(8'h40, 8'h00);
      cap0 <= 1'b1;
      settle();
      rdchk(CAPTURE_EDGE_STATUS_OFS, 8'h01);
      cap0 <= 1'b0;
      settle();
      rdchk(CAPTURE_EDGE_STATUS_OFS, 8'h03);
      cap1 <= 1'b1;
      settle();
      rdchk(CAPTURE_EDGE_STATUS_OFS, 8'h07);
      cap1 <= 1'b0;
      settle();
      rdchk(CAPTURE_EDGE_STATUS_OFS, 8'h0F);
      wr(CAPTURE_EDGE_STATUS_OFS, 8'h01);
      rdchk(CAPTURE_EDGE_STATUS_OFS, 8'h0E);
      wr(CAPTURE_EDGE_STATUS_OFS, 8'hF0);
      rdchk(CAPTURE_EDGE_STATUS_OFS, 8'h0E);
      wr(CAPTURE_EDGE_STATUS_OFS, 8'h0E);
      rdchk(CAPTURE_EDGE_STATUS_OFS, 8'h00);
   endtask : t_capture

   task automatic t_soft();
      rdchk(POSTED_CLEAR0_OFS, REG_RESET);
      wr(SOURCE_MASK3_OFS, 8'h80);
      wr(POSTED_CLEAR0_OFS, 8'h02);
      rdchk(POSTED_CLEAR0_OFS, 8'h02);
      wr(POSTED_CLEAR0_OFS, 8'h00);
      rdchk(POSTED_CLEAR0_OFS, 8'h02);
      wr(SOURCE_MASK3_OFS, 8'h00);
      wr(POSTED_CLEAR0_OFS, 8'hFF);
      rdchk(POSTED_CLEAR0_OFS, 8'h02);
      wr(POSTED_CLEAR0_OFS, 8'hFD);
      rdchk(POSTED_CLEAR0_OFS, 8'h00);
   endtask : t_soft

   // Masked post, unmask, then nesting and return with a second pending source
   task automatic t_dispatch();
      wr(SOURCE_MASK0_OFS, 8'h00);
      source_event <= 25'h0000002;
      @(posedge core_clk);
      source_event <= '0;
      cmd(1'b1, 1'b0);
      expect_none(30);
      rdchk(POSTED_CLEAR0_OFS, 8'h02);
      wr(SOURCE_MASK0_OFS, 8'h02);
      expect_dispatch(8'h08);
      rdchk(POSTED_CLEAR0_OFS, 8'h00);
      check1("irq enable", 1'b0, global_irq_enable);
      source_event <= 25'h0000003;
      @(posedge core_clk);
      source_event <= '0;
      wr(SOURCE_MASK0_OFS, 8'h03);
      expect_none(20);
      cmd(1'b1, 1'b0);
      expect_dispatch(8'h04);
      rdchk(POSTED_CLEAR0_OFS, 8'h02);
      cmd(1'b0, 1'b1);
      expect_dispatch(8'h08);
      cmd(1'b0, 1'b1);
      cmd(1'b0, 1'b1);
   endtask : t_dispatch

   task automatic t_bus();
      wr(SOURCE_MASK1_OFS, 8'hFF);
      bus_dp <= 1'b0;
      bus_dm <= 1'b1;
      // Hold long enough for two synchroniser stages to agree
      repeat (3) @(posedge core_clk);
      bus_dp <= 1'b1;
      bus_dm <= 1'b0;
      expect_dispatch(8'h30);
      clr_all();
      wr(SOURCE_MASK1_OFS, 8'h00);
      cmd(1'b0, 1'b1);
   endtask : t_bus

   task automatic t_low();
      wr(SOURCE_MASK2_OFS, 8'hFF);
      sin_mode <= 1'b1;
      serial_data_pad <= 1'b0;
      expect_dispatch(8'h4C);
      @(posedge core_clk);
      serial_data_pad <= 1'b1;
      clr_all();
      wr(SOURCE_MASK2_OFS, 8'h00);
      cmd(1'b0, 1'b1);
   endtask : t_low

   task automatic t_port();
      wr(SOURCE_MASK0_OFS, 8'hFF);
      port_pins <= 4'h1;
      expect_dispatch(8'h14);
      cmd(1'b0, 1'b1);
      expect_none(40);
   endtask : t_port

   initial begin
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      t_capture();
      t_soft();
      clr_all();
      t_dispatch();
      t_bus();
      t_low();
      t_port();
      summarize();
   end
endmodule : tb_top
